// ### rxpq_host.sv
// host side model: byte writes and reads on the register access port
// assumes the block takes a strobe on the rising edge and returns read data at that same edge
`timescale 1ns/1ps
module rxpq_host (
    // clock
    input wire logic clk,
    // register access
    output logic [7:0] addr,
    output logic [7:0] wdata,
    output logic wr,
    output logic rd
);
    initial begin
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end

    // also carried by this task
    // one strobe cycle; then strobes drop low and address and data show the inverse of the last value
    task automatic access(input logic [7:0] a, input logic [7:0] d, input logic is_wr);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = is_wr;
        rd = !is_wr;
        @(negedge clk);
        wr = 1'b0;
        rd = 1'b0;
        addr = ~a;
        wdata = ~d;
    endtask
endmodule

// ### rxpq_pkg.sv
// constants for the per-port equalizer, filter and interrupt-enable register group
// assumes an 8-bit register access port driven by the i2c target logic
package rxpq_pkg;
    localparam int NPORT = 4;
    localparam int NEVT = 9;
    // register offsets
    localparam logic [7:0] OFS_PORT_SEL = 8'h4C;
    localparam logic [7:0] OFS_EQ_LIMITS = 8'hD5;
    localparam logic [7:0] OFS_FILT_CLK = 8'hD6;
    localparam logic [7:0] OFS_FILT_DATA = 8'hD7;
    localparam logic [7:0] OFS_IE_HIGH = 8'hD8;
    localparam logic [7:0] OFS_IE_LOW = 8'hD9;
    // values after reset
    localparam logic [7:0] RST_PORT_SEL = 8'h01;
    localparam logic [3:0] RST_EQ_CEILING = 4'hF;
    localparam logic [3:0] RST_EQ_FLOOR = 4'h2;
    localparam logic [2:0] RST_IE_HIGH = 3'h0;
    localparam logic [6:0] RST_IE_LOW = 7'h00;
    localparam logic [5:0] RST_DELAY = 6'h00;
    // field positions
    localparam int CEIL_LSB = 4;
    localparam int FLOOR_LSB = 0;
    localparam int LIMIT_BIT = 7;
    localparam int SETTLED_BIT = 6;
    localparam int FAULT_BIT = 6;
    localparam int RD_SEL_LSB = 4;
    // pending-event vector positions; enable vector is {ie_high[2:0], ie_low[6:4], ie_low[2:0]}
    localparam int EV_LOCK = 0;
    localparam int EV_PORT_VALID = 1;
    localparam int EV_PARITY = 2;
    localparam int EV_OVERFLOW = 3;
    localparam int EV_LINE_CNT = 4;
    localparam int EV_LINE_LEN = 5;
    localparam int EV_CTRL_CRC = 6;
    localparam int EV_CTRL_SEQ = 7;
    localparam int EV_ENCODING = 8;
    // events cleared by reading each receive-port status register
    localparam logic [8:0] STS_ONE_MASK = 9'h0C7;
    localparam logic [8:0] STS_TWO_MASK = 9'h138;
endpackage

// ### rxpq_port_regs.sv
// one receive port's copy of the limits, filter status and interrupt enables
// assumes write and read strobes already gated by the port select
`timescale 1ns/1ps
module rxpq_port_regs (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // register access
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    // filter and equalizer side
    input wire logic filt_limit,
    input wire logic filt_settled,
    input wire logic filt_fault,
    input wire logic [5:0] clk_dly,
    input wire logic [5:0] data_dly,
    input wire logic floor_en,
    input wire logic [3:0] eq_req,
    output logic [3:0] eq_ceiling,
    output logic [3:0] eq_floor,
    output logic [3:0] eq_start,
    output logic [3:0] eq_level,
    // events
    input wire logic [8:0] evt,
    input wire logic sts_one_rd,
    input wire logic sts_two_rd,
    output logic [8:0] pending,
    output logic [8:0] enables,
    output logic [2:0] filt_flags,
    output logic irq
);
    logic [2:0] ie_high;
    logic [6:0] ie_low;
    logic limit_flag;
    logic settled_flag;
    logic fault_flag;
    logic rd_clk;
    logic rd_data;

    function automatic logic [3:0] clamp(input logic [3:0] v, input logic [3:0] lim);
        clamp = (v > lim) ? lim : v;
    endfunction

    assign rd_clk = rd && (addr == rxpq_pkg::OFS_FILT_CLK);
    assign rd_data = rd && (addr == rxpq_pkg::OFS_FILT_DATA);
    assign enables = {ie_high, ie_low[6:4], ie_low[2:0]};
    assign filt_flags = {limit_flag, settled_flag, fault_flag};

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            eq_ceiling <= rxpq_pkg::RST_EQ_CEILING;
            eq_floor <= rxpq_pkg::RST_EQ_FLOOR;
        end else if (wr && addr == rxpq_pkg::OFS_EQ_LIMITS) begin
            eq_ceiling <= wdata[rxpq_pkg::CEIL_LSB +: 4];
            eq_floor <= wdata[rxpq_pkg::FLOOR_LSB +: 4];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ie_high <= rxpq_pkg::RST_IE_HIGH;
            ie_low <= rxpq_pkg::RST_IE_LOW;
        end else if (wr) begin
            if (addr == rxpq_pkg::OFS_IE_HIGH) begin
                ie_high <= wdata[2:0];
            end
            if (addr == rxpq_pkg::OFS_IE_LOW) begin
                ie_low <= {wdata[6:4], 1'b0, wdata[2:0]};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            eq_level <= 4'h0;
            eq_start <= 4'h0;
        end else begin
            eq_level <= clamp(eq_req, eq_ceiling);
            eq_start <= floor_en ? clamp(eq_floor, eq_ceiling) : 4'h0;
        end
    end

    // limit flag; fault flag; set wins over read clear
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            limit_flag <= 1'b0;
            fault_flag <= 1'b0;
        end else begin
            limit_flag <= filt_limit | (limit_flag & ~rd_clk);
            fault_flag <= filt_fault | (fault_flag & ~rd_data);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            settled_flag <= 1'b0;
        end else if (rd_clk) begin
            settled_flag <= filt_settled;
        end else begin
            settled_flag <= settled_flag & filt_settled;
        end
    end

    // pending events cleared by status reads
    rxpq_sticky #(.W(9)) u_pending (
        .clk(clk),
        .rst_b(rst_b),
        .set(evt),
        .clr((sts_one_rd ? rxpq_pkg::STS_ONE_MASK : 9'h000) | (sts_two_rd ? rxpq_pkg::STS_TWO_MASK : 9'h000)),
        .flags(pending)
    );

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |(pending & enables);
        end
    end

    always_comb begin
        unique case (addr)
            rxpq_pkg::OFS_EQ_LIMITS: rdata = {eq_ceiling, eq_floor};
            rxpq_pkg::OFS_FILT_CLK: rdata = {limit_flag, settled_flag, clk_dly};
            rxpq_pkg::OFS_FILT_DATA: rdata = {1'b0, fault_flag, data_dly};
            rxpq_pkg::OFS_IE_HIGH: rdata = {5'h00, ie_high};
            rxpq_pkg::OFS_IE_LOW: rdata = {1'b0, ie_low};
            default: rdata = 8'h00;
        endcase
    end
endmodule

// ### rxpq_sticky.sv
// sticky flag bank: hardware set wins over a clear in the same cycle
// assumes set and clear come from logic on the same clock
`timescale 1ns/1ps
module rxpq_sticky #(
    parameter int W = 9
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // set and clear
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    // flags
    output logic [W-1:0] flags
);
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            flags <= '0;
        end else begin
            flags <= set | (flags & ~clr);
        end
    end
endmodule

// ### rxpq_top.sv
// per-receive-port equalizer limits, filter status and interrupt enables, four port copies
// assumes the i2c target gives one-cycle read and write strobes and that all inputs share REF_CLK
// What this block does
// - ceiling field bits 7:4 resets 0xF; equalizer never goes above it.
// - with floor enable set, adaptation starts from floor bits 3:0, reset 0x2.
// - limit flag bit 7 sets when filter maxes out; read clears it.
// - stable flag bit 6 latches low until read, then shows current status.
// - first filter status bits 5:0 return current clock delay input, with no reset to zero.
// - fault flag bit 6 sets on invalid measurement; reading clears it.
// - second filter status bits 5:0 return current data delay code.
// - each register except port select exists per port; port select decides which copy is reached.
// - high enable bit 2 lets an encoding fault raise the interrupt.
// - high enable bit 1 lets a control sequence fault raise the interrupt.
// - high enable bit 0 lets a control checksum fault raise the interrupt.
// - low enable bit 6 lets a line length change raise the interrupt.
// - low enable bit 5 lets a line count change raise the interrupt.
// - low enable bit 4 lets a receive overflow raise the interrupt.
// - low enable bit 2 lets a parity fault raise the interrupt.
// - low enable bit 1 lets a port-valid change raise the interrupt.
// - low enable bit 0 lets a lock change raise the interrupt.
// - pending conditions clear when the matching port status register is read.
// - floor enable makes adaptation start at floor, not zero; enable is the FLOOR_START_ENABLE input per port, with no reset here.
// - select bits 5:4 pick the read port; bits 3:0 enable writes per port.
`timescale 1ns/1ps
module rxpq_top (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST_B,
    // register access
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    // filter status per port
    input wire logic [3:0] FILT_LIMIT,
    input wire logic [3:0] FILT_SETTLED,
    input wire logic [3:0] FILT_FAULT,
    input wire logic [23:0] FILT_CLK_DLY,
    input wire logic [23:0] FILT_DATA_DLY,
    // equalizer per port
    input wire logic [3:0] FLOOR_START_ENABLE,
    input wire logic [15:0] EQ_REQ,
    output logic [15:0] EQ_CEILING,
    output logic [15:0] EQ_START,
    output logic [15:0] EQ_LEVEL,
    // events per port
    input wire logic [3:0] EVT_ENCODING,
    input wire logic [3:0] EVT_CTRL_SEQ,
    input wire logic [3:0] EVT_CTRL_CRC,
    input wire logic [3:0] EVT_LINE_LEN,
    input wire logic [3:0] EVT_LINE_CNT,
    input wire logic [3:0] EVT_OVERFLOW,
    input wire logic [3:0] EVT_PARITY,
    input wire logic [3:0] EVT_PORT_VALID,
    input wire logic [3:0] EVT_LOCK,
    // status register reads per port
    input wire logic [3:0] STS_ONE_READ,
    input wire logic [3:0] STS_TWO_READ,
    // interrupt per port
    output logic [3:0] IRQ
);
    logic [7:0] port_sel;
    logic [1:0] rd_port;
    logic [7:0] port_rdata [rxpq_pkg::NPORT];
    logic [8:0] port_pend [rxpq_pkg::NPORT];
    logic [8:0] port_en [rxpq_pkg::NPORT];
    logic [2:0] port_flags [rxpq_pkg::NPORT];
    logic [3:0] port_floor [rxpq_pkg::NPORT];
    logic [7:0] next_rdata;

    assign rd_port = port_sel[rxpq_pkg::RD_SEL_LSB +: 2];

    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            port_sel <= rxpq_pkg::RST_PORT_SEL;
        end else if (REG_WR && REG_ADDR == rxpq_pkg::OFS_PORT_SEL) begin
            port_sel <= {2'b00, REG_WDATA[5:0]};
        end
    end

    genvar p;
    generate
        for (p = 0; p < rxpq_pkg::NPORT; p++) begin : g_port
            rxpq_port_regs u_regs (
                .clk(REF_CLK),
                .rst_b(RST_B),
                .wr(REG_WR && port_sel[p]),
                .rd(REG_RD && rd_port == 2'(p)),
                .addr(REG_ADDR),
                .wdata(REG_WDATA),
                .rdata(port_rdata[p]),
                .filt_limit(FILT_LIMIT[p]),
                .filt_settled(FILT_SETTLED[p]),
                .filt_fault(FILT_FAULT[p]),
                .clk_dly(FILT_CLK_DLY[6*p +: 6]),
                .data_dly(FILT_DATA_DLY[6*p +: 6]),
                .floor_en(FLOOR_START_ENABLE[p]),
                .eq_req(EQ_REQ[4*p +: 4]),
                .eq_ceiling(EQ_CEILING[4*p +: 4]),
                .eq_floor(port_floor[p]),
                .eq_start(EQ_START[4*p +: 4]),
                .eq_level(EQ_LEVEL[4*p +: 4]),
                .evt({EVT_ENCODING[p], EVT_CTRL_SEQ[p], EVT_CTRL_CRC[p], EVT_LINE_LEN[p], EVT_LINE_CNT[p],
                      EVT_OVERFLOW[p], EVT_PARITY[p], EVT_PORT_VALID[p], EVT_LOCK[p]}),
                .sts_one_rd(STS_ONE_READ[p]),
                .sts_two_rd(STS_TWO_READ[p]),
                .pending(port_pend[p]),
                .enables(port_en[p]),
                .filt_flags(port_flags[p]),
                .irq(IRQ[p])
            );
        end
    endgenerate

    // read data from the selected port
    always_comb begin
        if (REG_ADDR == rxpq_pkg::OFS_PORT_SEL) begin
            next_rdata = port_sel;
        end else begin
            next_rdata = port_rdata[rd_port];
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            REG_RDATA <= 8'h00;
        end else if (REG_RD) begin
            REG_RDATA <= next_rdata;
        end
    end

    // checks on port 0 with port 0 selected for reads
    logic sel0;
    logic rd_clk0;
    logic rd_data0;
    assign sel0 = (rd_port == 2'b00);
    assign rd_clk0 = REG_RD && sel0 && REG_ADDR == rxpq_pkg::OFS_FILT_CLK;
    assign rd_data0 = REG_RD && sel0 && REG_ADDR == rxpq_pkg::OFS_FILT_DATA;

    AST_CEIL_CLAMP: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        1'b1 |=> EQ_LEVEL[3:0] == (($past(EQ_REQ[3:0]) > $past(EQ_CEILING[3:0])) ?
                                   $past(EQ_CEILING[3:0]) : $past(EQ_REQ[3:0])))
        else $error("equalizer level above ceiling");

    AST_FLOOR_START: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        FLOOR_START_ENABLE[0] && port_floor[0] <= EQ_CEILING[3:0]
        |=> EQ_START[3:0] == $past(port_floor[0]))
        else $error("adaptation not starting from floor");

    AST_NO_FLOOR: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        !FLOOR_START_ENABLE[0] |=> EQ_START[3:0] == 4'h0)
        else $error("adaptation start not zero without floor enable");

    AST_LIMIT_SET: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        FILT_LIMIT[0] |=> port_flags[0][2] ##1 (port_flags[0][2] || $past(rd_clk0)))
        else $error("limit flag lost before read");

    AST_LIMIT_CLR: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        rd_clk0 && !FILT_LIMIT[0] |=> !port_flags[0][2])
        else $error("limit flag not cleared by read");

    AST_SETTLED_LOW: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        !FILT_SETTLED[0] ##1 (!rd_clk0)[*2] |=> !port_flags[0][1])
        else $error("stable flag did not stay low until read");

    AST_SETTLED_RELOAD: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        rd_clk0 |=> port_flags[0][1] == $past(FILT_SETTLED[0]))
        else $error("stable flag not reloaded on read");

    AST_CLK_DLY_READ: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        rd_clk0 |=> REG_RDATA == {$past(port_flags[0][2]), $past(port_flags[0][1]), $past(FILT_CLK_DLY[5:0])})
        else $error("clock delay read-back wrong");

    AST_FAULT_READ: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        FILT_FAULT[0] ##1 rd_data0 |=> REG_RDATA[6] && REG_RDATA[5:0] == $past(FILT_DATA_DLY[5:0]))
        else $error("fault flag or data delay read-back wrong");

    AST_STS_CLEAR: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        STS_ONE_READ[0] && !EVT_LOCK[0] |=> !port_pend[0][rxpq_pkg::EV_LOCK])
        else $error("lock condition not cleared by status read");

    AST_IRQ_RAISE: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        EVT_OVERFLOW[0] ##1 port_en[0][rxpq_pkg::EV_OVERFLOW] |=> IRQ[0])
        else $error("enabled overflow did not raise irq");

    AST_IRQ_DROP: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        (port_pend[0] & port_en[0]) == 9'h000 |=> !IRQ[0])
        else $error("irq high with nothing enabled pending");

    AST_WRITE_GATED: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        REG_WR && !port_sel[0] && REG_ADDR == rxpq_pkg::OFS_IE_LOW |=> $stable(port_en[0]))
        else $error("write reached a port not enabled for writes");

    COV_IRQ: cover property (@(posedge REF_CLK) disable iff (!RST_B) !IRQ[0] ##1 IRQ[0]);
    COV_LIMIT_READ: cover property (@(posedge REF_CLK) disable iff (!RST_B) port_flags[0][2] && rd_clk0);
    COV_SETTLED_RELOAD: cover property (@(posedge REF_CLK) disable iff (!RST_B)
        !port_flags[0][1] && rd_clk0 && FILT_SETTLED[0]);
    COV_PORT3_READ: cover property (@(posedge REF_CLK) disable iff (!RST_B) REG_RD && rd_port == 2'b11);
endmodule

// ### rxpq_top_tb_top.sv
// self-checking bench for the four-port limits, filter status and interrupt-enable block
// assumes rxpq_host drives the register port and events are pulsed at the falling edge
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin miscompares++; $display("[FAIL] %s expected %0h seen %0h", nm, e, a); end end
module rxpq_top_tb_top;
    logic REF_CLK = 1'b0;
    logic RST_B = 1'b0;
    logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
    logic REG_WR, REG_RD;
    logic [3:0] FILT_LIMIT = 4'h0, FILT_SETTLED = 4'hF, FILT_FAULT = 4'h0, FLOOR_START_ENABLE = 4'hF;
    logic [3:0] STS_ONE_READ = 4'h0, STS_TWO_READ = 4'h0, IRQ;
    logic [23:0] FILT_CLK_DLY, FILT_DATA_DLY;
    logic [15:0] EQ_REQ, EQ_CEILING, EQ_START, EQ_LEVEL;
    logic [3:0] evt [9];
    int miscompares = 0;
    int n_tests = 0;
    int seed;
    string q_name [$];
    logic [7:0] q_val [$];
    string m_name;
    logic [7:0] m_val, rnd, en_adr;
    logic two;
    int en_bit;

    always #25 REF_CLK = ~REF_CLK;

    rxpq_host host (.clk(REF_CLK), .addr(REG_ADDR), .wdata(REG_WDATA), .wr(REG_WR), .rd(REG_RD));

    rxpq_top uut (
        .REF_CLK(REF_CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
        .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .FILT_LIMIT(FILT_LIMIT), .FILT_SETTLED(FILT_SETTLED),
        .FILT_FAULT(FILT_FAULT), .FILT_CLK_DLY(FILT_CLK_DLY), .FILT_DATA_DLY(FILT_DATA_DLY),
        .FLOOR_START_ENABLE(FLOOR_START_ENABLE), .EQ_REQ(EQ_REQ), .EQ_CEILING(EQ_CEILING),
        .EQ_START(EQ_START), .EQ_LEVEL(EQ_LEVEL), .EVT_ENCODING(evt[8]), .EVT_CTRL_SEQ(evt[7]),
        .EVT_CTRL_CRC(evt[6]), .EVT_LINE_LEN(evt[5]), .EVT_LINE_CNT(evt[4]), .EVT_OVERFLOW(evt[3]),
        .EVT_PARITY(evt[2]), .EVT_PORT_VALID(evt[1]), .EVT_LOCK(evt[0]), .STS_ONE_READ(STS_ONE_READ),
        .STS_TWO_READ(STS_TWO_READ), .IRQ(IRQ)
    );

    function automatic logic [3:0] min4(input logic [3:0] a, input logic [3:0] b);
        return (a < b) ? a : b;
    endfunction

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge REF_CLK);
    endtask

    // note the expected byte, then issue the read
    task automatic rd_exp(input logic [7:0] a, input logic [7:0] e, input string nm);
        q_name.push_back(nm);
        q_val.push_back(e);
        host.access(a, 8'h00, 1'b0);
    endtask

    task automatic pulse_evt(input int i);
        @(negedge REF_CLK);
        evt[i][0] = 1'b1;
        @(negedge REF_CLK);
        evt[i][0] = 1'b0;
    endtask

    task automatic pulse_sts(input logic grp_two);
        @(negedge REF_CLK);
        STS_ONE_READ[0] = !grp_two;
        STS_TWO_READ[0] = grp_two;
        @(negedge REF_CLK);
        STS_ONE_READ[0] = 1'b0;
        STS_TWO_READ[0] = 1'b0;
    endtask

    // read data lands on the rising edge that takes the strobe; check it at the next falling edge
    always @(posedge REF_CLK) begin
        if (REG_RD === 1'b1) begin
            @(negedge REF_CLK);
            m_name = q_name.pop_front();
            m_val = q_val.pop_front();
            `CHK(m_name, m_val, REG_RDATA)
        end
    end

    initial begin
        repeat (20000) @(posedge REF_CLK);
        miscompares++;
        complete_run();
    end

    initial begin
        seed = $urandom(51);
        FILT_CLK_DLY = 24'($urandom());
        FILT_DATA_DLY = 24'($urandom());
        EQ_REQ = 16'($urandom());
        foreach (evt[i]) evt[i] = 4'h0;
        repeat (4) @(negedge REF_CLK);
        RST_B = 1'b1;
        rd_exp(rxpq_pkg::OFS_EQ_LIMITS, 8'hF2, "limits reset");
        rd_exp(rxpq_pkg::OFS_IE_HIGH, 8'h00, "ie high reset");
        rd_exp(rxpq_pkg::OFS_IE_LOW, 8'h00, "ie low reset");
        rd_exp(rxpq_pkg::OFS_PORT_SEL, 8'h01, "select reset");
        rd_exp(8'hD1, 8'h00, "unmapped");
        `CHK("start floor", 4'h2, EQ_START[3:0])
        host.access(rxpq_pkg::OFS_FILT_CLK, 8'hFF, 1'b1);
        rd_exp(rxpq_pkg::OFS_FILT_CLK, {2'b00, FILT_CLK_DLY[5:0]}, "clk sts reset");
        rd_exp(rxpq_pkg::OFS_FILT_CLK, {2'b01, FILT_CLK_DLY[5:0]}, "stable");
        @(negedge REF_CLK);
        FILT_SETTLED[0] = 1'b0;
        @(negedge REF_CLK);
        FILT_SETTLED[0] = 1'b1;
        wait_cyc(1);
        rd_exp(rxpq_pkg::OFS_FILT_CLK, {2'b00, FILT_CLK_DLY[5:0]}, "stable latched");
        @(negedge REF_CLK);
        FILT_LIMIT[0] = 1'b1;
        @(negedge REF_CLK);
        FILT_LIMIT[0] = 1'b0;
        rd_exp(rxpq_pkg::OFS_FILT_CLK, {2'b11, FILT_CLK_DLY[5:0]}, "limit set");
        rd_exp(rxpq_pkg::OFS_FILT_CLK, {2'b01, FILT_CLK_DLY[5:0]}, "limit clear");
        // fault still high while read: set wins, so the next read shows it again
        @(negedge REF_CLK);
        FILT_FAULT[0] = 1'b1;
        rd_exp(rxpq_pkg::OFS_FILT_DATA, {2'b01, FILT_DATA_DLY[5:0]}, "fault set");
        FILT_FAULT[0] = 1'b0;
        rd_exp(rxpq_pkg::OFS_FILT_DATA, {2'b01, FILT_DATA_DLY[5:0]}, "fault set wins");
        rd_exp(rxpq_pkg::OFS_FILT_DATA, {2'b00, FILT_DATA_DLY[5:0]}, "fault clear");
        host.access(rxpq_pkg::OFS_IE_HIGH, 8'hFF, 1'b1);
        host.access(rxpq_pkg::OFS_IE_LOW, 8'hFF, 1'b1);
        rd_exp(rxpq_pkg::OFS_IE_HIGH, 8'h07, "ie high rsvd");
        rd_exp(rxpq_pkg::OFS_IE_LOW, 8'h77, "ie low rsvd");
        host.access(rxpq_pkg::OFS_IE_HIGH, 8'h00, 1'b1);
        host.access(rxpq_pkg::OFS_IE_LOW, 8'h00, 1'b1);
        // each event: masked, enabled, held through the wrong status read, cleared by the right one
        for (int i = 0; i < rxpq_pkg::NEVT; i++) begin
            en_adr = (i < 6) ? rxpq_pkg::OFS_IE_LOW : rxpq_pkg::OFS_IE_HIGH;
            en_bit = (i < 3) ? i : ((i < 6) ? i + 1 : i - 6);
            two = rxpq_pkg::STS_TWO_MASK[i];
            pulse_evt(i);
            wait_cyc(2);
            `CHK("irq masked", 4'h0, IRQ)
            pulse_sts(two);
            host.access(en_adr, 8'(1 << en_bit), 1'b1);
            pulse_evt(i);
            wait_cyc(2);
            `CHK("irq raised", 4'h1, IRQ)
            pulse_sts(!two);
            wait_cyc(2);
            `CHK("irq held", 4'h1, IRQ)
            pulse_sts(two);
            wait_cyc(2);
            `CHK("irq cleared", 4'h0, IRQ)
            host.access(en_adr, 8'h00, 1'b1);
        end
        for (int p = 1; p < 4; p++) begin
            host.access(rxpq_pkg::OFS_PORT_SEL, {2'b11, 2'(p), 4'h1}, 1'b1);
            rd_exp(rxpq_pkg::OFS_PORT_SEL, {2'b00, 2'(p), 4'h1}, "select");
            rd_exp(rxpq_pkg::OFS_FILT_CLK, {2'b00, FILT_CLK_DLY[6*p +: 6]}, "port clk");
            rd_exp(rxpq_pkg::OFS_FILT_DATA, {2'b00, FILT_DATA_DLY[6*p +: 6]}, "port data");
        end
        rnd = 8'($urandom());
        host.access(rxpq_pkg::OFS_PORT_SEL, 8'h02, 1'b1);
        host.access(rxpq_pkg::OFS_EQ_LIMITS, rnd, 1'b1);
        host.access(rxpq_pkg::OFS_IE_LOW, rnd, 1'b1);
        rd_exp(rxpq_pkg::OFS_EQ_LIMITS, 8'hF2, "unselected port");
        rd_exp(rxpq_pkg::OFS_IE_LOW, 8'h00, "unselected enables");
        host.access(rxpq_pkg::OFS_PORT_SEL, 8'h12, 1'b1);
        rd_exp(rxpq_pkg::OFS_EQ_LIMITS, rnd, "selected port");
        rd_exp(rxpq_pkg::OFS_IE_LOW, {1'b0, rnd[6:4], 1'b0, rnd[2:0]}, "port enables");
        // write ports 0 and 1 together, read port 1
        host.access(rxpq_pkg::OFS_PORT_SEL, 8'h13, 1'b1);
        host.access(rxpq_pkg::OFS_EQ_LIMITS, rnd, 1'b1);
        wait_cyc(1);
        `CHK("ceiling", rnd[7:4], EQ_CEILING[7:4])
        `CHK("ceiling p0", rnd[7:4], EQ_CEILING[3:0])
        `CHK("eq level", min4(EQ_REQ[7:4], rnd[7:4]), EQ_LEVEL[7:4])
        `CHK("eq level p0", min4(EQ_REQ[3:0], rnd[7:4]), EQ_LEVEL[3:0])
        for (int fe = 0; fe < 2; fe++) begin
            FLOOR_START_ENABLE[1:0] = {2{1'(fe)}};
            wait_cyc(2);
            `CHK("eq start", (fe == 1) ? min4(rnd[3:0], rnd[7:4]) : 4'h0, EQ_START[7:4])
            `CHK("eq start p0", (fe == 1) ? min4(rnd[3:0], rnd[7:4]) : 4'h0, EQ_START[3:0])
        end
        wait_cyc(2);
        complete_run();
    end
endmodule
